// ===== include/airtc_defines.svh
/*
 Offsets, field positions, reset values and timing counts of the
 ambient infrared ADC timing configuration block.
 Assumes inclusion by bare name from files under verilog/ and include/.
*/
`ifndef AIRTC_DEFINES_SVH
`define AIRTC_DEFINES_SVH

// register indices; byte address is four times the index
`define AIRTC_IDX_LED_SPARE 6'h1C
`define AIRTC_IDX_REC_PERIOD 6'h1D
`define AIRTC_IDX_INT_SCALE 6'h1E
`define AIRTC_IDX_SPAN_SEL 6'h1F
`define AIRTC_IDX_CTRL 6'h20
`define AIRTC_IDX_STATUS 6'h21

// field positions
`define AIRTC_REC_CODE_HI 6
`define AIRTC_REC_CODE_LO 4
`define AIRTC_SCALE_HI 2
`define AIRTC_SCALE_LO 0
`define AIRTC_SPAN_BIT 5
`define AIRTC_SPAN_KEEP_HI 4
`define AIRTC_CTRL_START_BIT 0
`define AIRTC_STAT_BUSY_BIT 0
`define AIRTC_STAT_DONE_BIT 1

// reset values
`define AIRTC_RST_LED_SPARE 8'h00
`define AIRTC_RST_REC_PERIOD 8'h70
`define AIRTC_RST_INT_SCALE 8'h00
`define AIRTC_RST_SPAN_SEL 8'h00

// sequencer revision codes
`define AIRTC_SEQ_REV_A03 8'h03

// timing: undivided ADC clock period over the system clock period
`define AIRTC_ADC_CLK_NS 50
`define AIRTC_SYS_CLK_NS 10
`define AIRTC_ADC_CLK_CYC ((`AIRTC_ADC_CLK_NS + `AIRTC_SYS_CLK_NS - 1) / `AIRTC_SYS_CLK_NS)
// base integration length in ADC clocks before scaling
`define AIRTC_BASE_INT_CLKS 16

`endif

// ===== include/airtc_pkg.sv
/*
 Types shared by the ambient infrared ADC timing configuration block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package airtc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_RECOVER, ST_INTEGRATE, ST_STORE} airtc_state_t;
endpackage

// ===== verilog/airtc_tick_div.sv
/*
 ADC clock enable divider: one-cycle tick every base*2^shift system cycles.
 Assumes a single system clock with synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "airtc_defines.svh"

module airtc_tick_div
(
	input wire logic i_clk, // system clock
	input wire logic i_srst, // sync reset, high
	input wire logic i_run, // count while high, restart when low
	input wire logic [2:0] i_shift, // power-of-two divide exponent
	output logic o_tick // one-cycle ADC clock enable
);
	import airtc_pkg::*;

	localparam logic [9:0] BASE_CYC = 10'(`AIRTC_ADC_CLK_CYC);

	logic [9:0] cnt_reg;
	logic [9:0] term;

	assign term = 10'(BASE_CYC << i_shift);
	assign o_tick = i_run && (cnt_reg == term - 10'h001);

	always_ff @(posedge i_clk)
	begin
		if (i_srst || !i_run || o_tick)
			cnt_reg <= 10'h000;
		else
			cnt_reg <= cnt_reg + 10'h001;
	end
endmodule
`default_nettype wire

// ===== verilog/airtc_top.sv
/*
 Ambient infrared ADC timing configuration: APB register file holding the
 recovery period, integration scale, signal span and spare LED byte, plus the
 measurement sequencer that applies all but the spare LED byte.
 Assumes an APB master on I_CLK and an ADC front end that follows the
 recovering / integrating / store strobes on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "airtc_defines.svh"

module airtc_top
#(
	parameter logic [7:0] P_SEQ_REV = `AIRTC_SEQ_REV_A03 // sequencer revision
)
(
	input wire logic I_CLK, // system clock, 100 MHz
	input wire logic I_SRST, // sync reset, high
	input wire logic [7:0] I_PADDR, // apb byte address
	input wire logic I_PSEL, // apb select
	input wire logic I_PENABLE, // apb access phase
	input wire logic I_PWRITE, // apb direction
	input wire logic [31:0] I_PWDATA, // apb write data
	input wire logic [3:0] I_PSTRB, // apb byte strobes
	output logic [31:0] O_PRDATA, // apb read data
	output logic O_PREADY, // apb ready
	output logic O_PSLVERR, // apb error on unmapped address
	output logic O_IR_CLK_EN, // ADC clock enable tick
	output logic O_IR_RECOVERING, // recovery in progress
	output logic O_IR_INTEGRATING, // integration in progress
	output logic O_IR_RESULT_STORE, // result hand-off pulse
	output logic O_IR_SPAN_HIGH, // high signal range in use
	output logic [2:0] O_IR_SCALE, // applied scale exponent
	output airtc_pkg::airtc_state_t O_SEQ_STATE // sequencer state
);
	import airtc_pkg::*;

	localparam logic REV_OK = (P_SEQ_REV >= `AIRTC_SEQ_REV_A03);
	localparam logic [4:0] BASE_INT_LAST = 5'(`AIRTC_BASE_INT_CLKS - 1);
	// named bytes so that reset fields can be part-selected
	localparam logic [7:0] RST_REC_BYTE = `AIRTC_RST_REC_PERIOD;
	localparam logic [7:0] RST_SCALE_BYTE = `AIRTC_RST_INT_SCALE;
	localparam logic [7:0] RST_SPAN_BYTE = `AIRTC_RST_SPAN_SEL;

	logic [7:0] led_spare_reg;
	logic [2:0] rec_code_reg;
	logic [2:0] scale_reg;
	logic span_reg;
	logic [4:0] span_keep_reg;
	logic done_reg;
	logic [31:0] prdata_reg;
	logic slverr_reg;
	airtc_state_t state_reg;
	airtc_state_t state_next;
	logic [2:0] rec_code_lat_reg;
	logic [2:0] scale_lat_reg;
	logic span_lat_reg;
	logic [8:0] rec_cnt_reg;
	logic [4:0] int_cnt_reg;
	logic [8:0] rec_last;
	logic tick;
	logic wr_en;
	logic rd_setup;
	logic wr_lane0;
	logic start_req;
	logic addr_ok;
	logic [5:0] idx;
	logic [7:0] rd_byte;

	assign idx = I_PADDR[7:2];
	assign addr_ok = (I_PADDR[1:0] == 2'h0) && (idx >= `AIRTC_IDX_LED_SPARE) && (idx <= `AIRTC_IDX_STATUS);
	assign wr_en = I_PSEL && I_PENABLE && I_PWRITE && addr_ok;
	assign wr_lane0 = wr_en && I_PSTRB[0];
	assign rd_setup = I_PSEL && !I_PENABLE;
	assign start_req = wr_lane0 && (idx == `AIRTC_IDX_CTRL) && I_PWDATA[`AIRTC_CTRL_START_BIT];

	// zero-wait slave: read data is captured during setup
	assign O_PREADY = 1'b1;
	assign O_PRDATA = prdata_reg;
	assign O_PSLVERR = slverr_reg && I_PSEL && I_PENABLE;

	always_comb
	begin
		rd_byte = 8'h00;
		unique case (idx)
			`AIRTC_IDX_LED_SPARE: rd_byte = led_spare_reg;
			`AIRTC_IDX_REC_PERIOD: rd_byte = {1'b0, rec_code_reg, 4'h0};
			`AIRTC_IDX_INT_SCALE: rd_byte = {5'h00, scale_reg};
			`AIRTC_IDX_SPAN_SEL: rd_byte = {2'h0, span_reg, span_keep_reg};
			`AIRTC_IDX_STATUS: rd_byte = {6'h00, done_reg, state_reg != ST_IDLE};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			prdata_reg <= 32'h0000_0000;
			slverr_reg <= 1'b0;
		end
		else if (rd_setup)
		begin
			prdata_reg <= {24'h00_0000, (addr_ok && !I_PWRITE) ? rd_byte : 8'h00};
			slverr_reg <= !addr_ok;
		end
	end

	// configuration registers; reserved bits of the recovery byte read as zero
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			led_spare_reg <= `AIRTC_RST_LED_SPARE;
			rec_code_reg <= RST_REC_BYTE[`AIRTC_REC_CODE_HI:`AIRTC_REC_CODE_LO];
			scale_reg <= RST_SCALE_BYTE[`AIRTC_SCALE_HI:`AIRTC_SCALE_LO];
			span_reg <= RST_SPAN_BYTE[`AIRTC_SPAN_BIT];
			span_keep_reg <= RST_SPAN_BYTE[`AIRTC_SPAN_KEEP_HI:0];
		end
		else if (wr_lane0)
		begin
			unique case (idx)
				`AIRTC_IDX_LED_SPARE: led_spare_reg <= I_PWDATA[7:0];
				`AIRTC_IDX_REC_PERIOD: rec_code_reg <= I_PWDATA[`AIRTC_REC_CODE_HI:`AIRTC_REC_CODE_LO];
				`AIRTC_IDX_INT_SCALE: scale_reg <= I_PWDATA[`AIRTC_SCALE_HI:`AIRTC_SCALE_LO];
				`AIRTC_IDX_SPAN_SEL:
				begin
					span_reg <= I_PWDATA[`AIRTC_SPAN_BIT];
					// stored as written; software is expected to write back what it read
					span_keep_reg <= I_PWDATA[`AIRTC_SPAN_KEEP_HI:0];
				end
				default: led_spare_reg <= led_spare_reg;
			endcase
		end
	end

	// settings are latched at start so a mid-measurement write cannot tear a conversion
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			rec_code_lat_reg <= 3'h0;
			scale_lat_reg <= 3'h0;
			span_lat_reg <= 1'b0;
		end
		else if (state_reg == ST_IDLE && start_req)
		begin
			rec_code_lat_reg <= rec_code_reg;
			scale_lat_reg <= REV_OK ? scale_reg : 3'h0;
			span_lat_reg <= REV_OK ? span_reg : 1'b0;
		end
	end

	airtc_tick_div u_tick_div
	(
		.i_clk(I_CLK),
		.i_srst(I_SRST),
		.i_run(state_reg != ST_IDLE && state_reg != ST_STORE),
		.i_shift(scale_lat_reg),
		.o_tick(tick)
	);

	// code 0 is a single clock; other codes run 2^(code+2)-1 clocks, last tick index below
	assign rec_last = (rec_code_lat_reg == 3'h0) ? 9'h000 : 9'((10'h004 << rec_code_lat_reg) - 10'h002);

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: if (start_req) state_next = ST_RECOVER;
			ST_RECOVER: if (tick && rec_cnt_reg == rec_last) state_next = ST_INTEGRATE;
			ST_INTEGRATE: if (tick && int_cnt_reg == BASE_INT_LAST) state_next = ST_STORE;
			ST_STORE: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// recovery and integration counts advance only on divided ADC ticks
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST || state_reg == ST_IDLE)
		begin
			rec_cnt_reg <= 9'h000;
			int_cnt_reg <= 5'h00;
		end
		else if (tick && state_reg == ST_RECOVER)
			rec_cnt_reg <= rec_cnt_reg + 9'h001;
		else if (tick && state_reg == ST_INTEGRATE)
			int_cnt_reg <= int_cnt_reg + 5'h01;
	end

	// done flag: a store in the clearing cycle keeps it set
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			done_reg <= 1'b0;
		else if (state_reg == ST_STORE)
			done_reg <= 1'b1;
		else if (wr_lane0 && idx == `AIRTC_IDX_STATUS && I_PWDATA[`AIRTC_STAT_DONE_BIT])
			done_reg <= 1'b0;
	end

	assign O_IR_CLK_EN = tick;
	assign O_IR_RECOVERING = (state_reg == ST_RECOVER);
	assign O_IR_INTEGRATING = (state_reg == ST_INTEGRATE);
	assign O_IR_RESULT_STORE = (state_reg == ST_STORE);
	assign O_IR_SPAN_HIGH = span_lat_reg;
	assign O_IR_SCALE = scale_lat_reg;
	assign O_SEQ_STATE = state_reg;

	// helper: cycles since the last tick inside a measurement
	logic [9:0] gap_reg;
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST || state_reg == ST_IDLE || state_reg == ST_STORE || tick)
			gap_reg <= 10'h000;
		else
			gap_reg <= gap_reg + 10'h001;
	end

	AST_TICK_PERIOD: assert property (@(posedge I_CLK) disable iff (I_SRST)
		tick |-> gap_reg == 10'((10'(`AIRTC_ADC_CLK_CYC) << scale_lat_reg) - 10'h001))
		else $error("adc tick spacing does not match the scale");

	AST_TICK_MIN_GAP: assert property (@(posedge I_CLK) disable iff (I_SRST)
		tick |=> !tick [*4])
		else $error("adc ticks closer than one undivided adc clock");

	AST_REC_END: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(state_reg == ST_RECOVER && tick && rec_cnt_reg == rec_last) |=> state_reg == ST_INTEGRATE)
		else $error("recovery did not end after its programmed length");

	AST_REC_NOT_EARLY: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(state_reg == ST_RECOVER && rec_cnt_reg != rec_last) |=> state_reg == ST_RECOVER)
		else $error("recovery left early");

	AST_INT_LEN: assert property (@(posedge I_CLK) disable iff (I_SRST)
		$rose(O_IR_RESULT_STORE) |-> $past(int_cnt_reg) == BASE_INT_LAST && $past(tick))
		else $error("integration ended at the wrong count");

	AST_ORDER: assert property (@(posedge I_CLK) disable iff (I_SRST)
		$rose(O_IR_INTEGRATING) |-> $past(state_reg) == ST_RECOVER)
		else $error("integration began without recovery");

	AST_STORE_PULSE: assert property (@(posedge I_CLK) disable iff (I_SRST)
		O_IR_RESULT_STORE |=> !O_IR_RESULT_STORE && done_reg && state_reg == ST_IDLE)
		else $error("store strobe not a single pulse with done set");

	AST_SPAN_LATCH: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(state_reg == ST_IDLE && start_req) |=> O_IR_SPAN_HIGH == (REV_OK && $past(span_reg)))
		else $error("span select not applied at start");

	AST_LEGACY_REV: assert property (@(posedge I_CLK) disable iff (I_SRST)
		!REV_OK |-> O_IR_SCALE == 3'h0 && !O_IR_SPAN_HIGH)
		else $error("scale or span acted on an old sequencer revision");
endmodule
`default_nettype wire

// ===== tb/tb_airtc_top.sv
/*
 Self-checking bench for the ambient infrared ADC timing block: register
 resets, read-back, refusals and one measurement per scale code.
 Assumes airtc_pkg is compiled first and a zero-wait APB slave.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_airtc_top;
	import airtc_pkg::*;
	logic clk, srst, psel, pen, pwr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic pready, pslverr, tick, recov, integ, store, span_hi, old_span, err;
	logic [2:0] scale, old_scale;
	airtc_state_t st;
	int num_errors = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h0000_000A;
	logic [7:0] a;

	airtc_top i_dut (.I_CLK(clk), .I_SRST(srst), .I_PADDR(paddr), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .O_IR_CLK_EN(tick), .O_IR_RECOVERING(recov), .O_IR_INTEGRATING(integ),
		.O_IR_RESULT_STORE(store), .O_IR_SPAN_HIGH(span_hi), .O_IR_SCALE(scale), .O_SEQ_STATE(st));
	// older sequencer on the same bus: scale and span must stay off
	airtc_top #(.P_SEQ_REV(8'h02)) i_old (.I_CLK(clk), .I_SRST(srst), .I_PADDR(paddr), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(), .O_PREADY(),
		.O_PSLVERR(), .O_IR_CLK_EN(), .O_IR_RECOVERING(), .O_IR_INTEGRATING(), .O_IR_RESULT_STORE(),
		.O_IR_SPAN_HIGH(old_span), .O_IR_SCALE(old_scale), .O_SEQ_STATE());

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	// bits that each register keeps and reads back
	function automatic logic [7:0] rmask(input logic [7:0] adr);
		case (adr)
			8'h70: return 8'hFF;
			8'h74: return 8'h70;
			8'h78: return 8'h07;
			default: return 8'h3F;
		endcase
	endfunction

	// recovery length in adc clocks for a given code
	function automatic int rec_clks(input int c);
		return (c == 0) ? 1 : ((4 << c) - 1);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] adr, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= adr;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic meas(input logic [2:0] s, input logic [2:0] c, input logic sp);
		int r, g, t;
		r = 0;
		g = 0;
		t = 0;
		apb(1'b1, 8'h78, {29'h0, s}, 4'h1);
		apb(1'b1, 8'h74, {25'h0, c, 4'h0}, 4'h1);
		apb(1'b0, 8'h7C, 32'h0000_0000, 4'h1);
		apb(1'b1, 8'h7C, {rd[31:6], sp, rd[4:0]}, 4'h1);
		apb(1'b1, 8'h80, 32'h0000_0001, 4'h1);
		@(negedge clk);
		chk({31'h0, recov}, 32'h0000_0001);
		chk({30'h0, st}, {30'h0, ST_RECOVER});
		chk({29'h0, scale}, {29'h0, s});
		chk({31'h0, span_hi}, {31'h0, sp});
		chk({28'h0, old_scale, old_span}, 32'h0000_0000);
		while (recov === 1'b1)
		begin
			r++;
			@(negedge clk);
		end
		chk(32'(r), 32'((5 << s) * rec_clks(int'(c))));
		while (integ === 1'b1)
		begin
			g++;
			if (tick === 1'b1)
				t++;
			@(negedge clk);
		end
		chk(32'(g), 32'((5 << s) * 16));
		chk(32'(t), 32'h0000_0010);
		chk({31'h0, store}, 32'h0000_0001);
		chk({30'h0, st}, {30'h0, ST_STORE});
		apb(1'b0, 8'h84, 32'h0000_0000, 4'h1);
		chk(rd, 32'h0000_0002);
		apb(1'b1, 8'h84, 32'h0000_0002, 4'h1);
		apb(1'b0, 8'h84, 32'h0000_0000, 4'h1);
		chk(rd, 32'h0000_0000);
	endtask

	task end_sim;
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		srst = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, 8'h70 + 8'(4 * i), 32'h0000_0000, 4'h1);
			chk(rd, (i == 1) ? 32'h0000_0070 : 32'h0000_0000);
		end
		// a write without the low strobe must not land
		apb(1'b1, 8'h70, 32'h0000_00A5, 4'h0);
		apb(1'b0, 8'h70, 32'h0000_0000, 4'h1);
		chk(rd, 32'h0000_0000);
		for (int i = 0; i < 3; i++)
		begin
			a = (i == 0) ? 8'h00 : ((i == 1) ? 8'h71 : 8'h88);
			apb(1'b0, a, 32'h0000_0000, 4'h1);
			chk({err, rd[30:0]}, 32'h8000_0000);
		end
		repeat (12)
		begin
			seed = xs(seed);
			a = 8'h70 + {4'h0, seed[9:8], 2'b00};
			apb(1'b1, a, seed, 4'h1);
			apb(1'b0, a, 32'h0000_0000, 4'h1);
			chk(rd, {24'h00_0000, seed[7:0] & rmask(a)});
		end
		for (int s = 0; s < 8; s++)
		begin
			seed = xs(seed);
			meas(3'(s), ~3'(s), seed[0]);
		end
		end_sim;
	end

	initial
	begin
		repeat (80000) @(posedge clk);
		num_errors++;
		end_sim;
	end
endmodule

`default_nettype wire
